// [include/i2cs_pkg.sv]
// Purpose: shared constants for the i2c slave port
// Assumes: 25 MHz core clock, scl and sda sampled as plain inputs
// Notes: states of the byte engine live here too
package i2cs_pkg;
  // ************************************************
  // addressing
  // ************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h51; // 1010001
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // ************************************************
  // bit counting and fields
  // ************************************************
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int SYNC_DEPTH = 2;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ************************************************
  // byte engine states
  // ************************************************
  typedef enum logic [2:0] {
    I2CS_IDLE,
    I2CS_RECV,
    I2CS_ACK,
    I2CS_SEND,
    I2CS_MACK,
    I2CS_IGNORE
  } i2cs_state_t;
endpackage : i2cs_pkg

// [verilog/i2cs_sync.sv]
// Purpose: two flip-flop synchroniser for one bus pin
// Assumes: input is asynchronous to core_clk_i
// Notes: reset value is the idle (released) level
`timescale 1ns/1ps
module i2cs_sync (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic sync_o
);
  logic meta_reg;
  // ************************************************
  // two stage capture
  // ************************************************
  // meta_reg is read only by the second stage
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta_reg <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_o <= meta_reg;
    end
  end
endmodule : i2cs_sync

// [verilog/i2cs_port.sv]
// Purpose: slave-only i2c port of a real-time clock, register side as strobes
// Assumes: scl and sda are oversampled by core_clk_i (40 ns vs 320 ns bench scl)
// Notes: sda is open drain: sda_oe_o high pulls the wire low
// How it works
// - sda change while scl high is control
// - sda fall with scl high starts
// - sda rise with scl high stops
// - slave only, never drives start/stop
// - eight bits then one ack clock
// - addressed receiver acks every byte
// - acker holds sda low through scl high
// - on master nack, release sda high
// - respond only to address 1010001
// - address lsb: 1 read, 0 write
// - stop ends a write
// - on battery, ignore all bus activity
// - aborted transfer marks time state invalid
`timescale 1ns/1ps
module i2cs_port (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic on_battery_i,
  input wire logic [7:0] rd_data_i,
  output logic sda_oe_o,
  output logic sda_out_o,
  output logic [7:0] reg_ptr_o,
  output logic [7:0] wr_data_o,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic busy_o,
  output logic time_invalid_o
);
  logic scl_s;
  logic sda_s;
  logic bat_s;
  logic scl_d_reg;
  logic sda_d_reg;
  i2cs_pkg::i2cs_state_t state_reg;
  i2cs_pkg::i2cs_state_t state_next;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;
  logic addr_phase_reg;
  logic ptr_phase_reg;
  logic dir_reg;
  logic nack_reg;
  logic ack_arm_reg;

  // ************************************************
  // pin synchronisers
  // ************************************************
  i2cs_sync u_scl (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(scl_i),
    .sync_o(scl_s)
  );
  i2cs_sync u_sda (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(sda_i),
    .sync_o(sda_s)
  );
  i2cs_sync u_bat (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(on_battery_i),
    .sync_o(bat_s)
  );

  // ************************************************
  // condition and edge decode
  // ************************************************
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  // sda moving while scl stays high is never data
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_done = scl_rise & (bit_reg == i2cs_pkg::BIT_LAST);
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  wire addr_hit = (rx_byte[7:1] == i2cs_pkg::SLAVE_ADDR);
  wire addr_read = (rx_byte[0] == i2cs_pkg::DIR_READ);
  wire in_frame = (state_reg != i2cs_pkg::I2CS_IDLE);
  // battery taking over inside a frame leaves the time state suspect
  wire abort_det = bat_s & in_frame;
  // the ack clock opens only at the fall that ends bit eight
  wire in_ack_clk = ack_arm_reg || scl_fall;
  wire ack_end = scl_fall && ack_arm_reg;

  // ************************************************
  // next state
  // ************************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      i2cs_pkg::I2CS_IDLE:
        state_next = state_reg;
      i2cs_pkg::I2CS_RECV:
        if (byte_done)
          state_next = (addr_phase_reg && !addr_hit) ? i2cs_pkg::I2CS_IGNORE
                                                     : i2cs_pkg::I2CS_ACK;
      i2cs_pkg::I2CS_ACK:
        if (ack_end)
          state_next = dir_reg ? i2cs_pkg::I2CS_SEND : i2cs_pkg::I2CS_RECV;
      i2cs_pkg::I2CS_SEND:
        if (byte_done)
          state_next = i2cs_pkg::I2CS_MACK;
      i2cs_pkg::I2CS_MACK:
        if (ack_end)
          state_next = nack_reg ? i2cs_pkg::I2CS_IGNORE : i2cs_pkg::I2CS_SEND;
      i2cs_pkg::I2CS_IGNORE:
        state_next = state_reg;
      default:
        state_next = i2cs_pkg::I2CS_IDLE;
    endcase
    // start or stop override any byte position; no bus at all on battery
    if (bat_s)
      state_next = i2cs_pkg::I2CS_IDLE;
    else if (start_det)
      state_next = i2cs_pkg::I2CS_RECV;
    else if (stop_det)
      state_next = i2cs_pkg::I2CS_IDLE;
  end

  // ************************************************
  // edge history and state
  // ************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= i2cs_pkg::I2CS_IDLE;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      state_reg <= state_next;
    end
  end

  // ************************************************
  // ack clock tracking
  // ************************************************
  // armed by the fall after bit eight; leaving ack or mack disarms
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || (state_next != i2cs_pkg::I2CS_ACK && state_next != i2cs_pkg::I2CS_MACK))
      ack_arm_reg <= 1'b0;
    else if (scl_fall)
      ack_arm_reg <= 1'b1;
  end

  // ************************************************
  // bit counter and shifter
  // ************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || start_det || state_next == i2cs_pkg::I2CS_ACK ||
        state_next == i2cs_pkg::I2CS_MACK)
      bit_reg <= i2cs_pkg::BIT_FIRST;
    else if (scl_rise)
      bit_reg <= bit_reg + 3'h1;
    if (srst_i)
      shift_reg <= i2cs_pkg::BYTE_ZERO;
    else if (state_reg == i2cs_pkg::I2CS_ACK && ack_end && dir_reg)
      shift_reg <= rd_data_i; // load byte to send
    else if (state_reg == i2cs_pkg::I2CS_MACK && ack_end)
      shift_reg <= rd_data_i;
    else if (state_reg == i2cs_pkg::I2CS_SEND && scl_fall)
      shift_reg <= {shift_reg[6:0], 1'b1}; // msb first
    else if (state_reg == i2cs_pkg::I2CS_RECV && scl_rise)
      shift_reg <= rx_byte;
  end

  // ************************************************
  // transfer phase, direction, master ack
  // ************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || start_det)
    begin
      addr_phase_reg <= 1'b1;
      ptr_phase_reg <= 1'b1;
      dir_reg <= i2cs_pkg::DIR_WRITE;
      nack_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == i2cs_pkg::I2CS_RECV && byte_done)
      begin
        addr_phase_reg <= 1'b0;
        if (addr_phase_reg)
          dir_reg <= addr_read;
        else
          ptr_phase_reg <= 1'b0;
      end
      if (state_reg == i2cs_pkg::I2CS_MACK && scl_rise)
        nack_reg <= sda_s;
    end
  end

  // ************************************************
  // register side: pointer and strobes
  // ************************************************
  wire data_wr = state_reg == i2cs_pkg::I2CS_RECV && byte_done &&
                 !addr_phase_reg && !ptr_phase_reg;
  wire ptr_ld = state_reg == i2cs_pkg::I2CS_RECV && byte_done &&
                !addr_phase_reg && ptr_phase_reg;
  wire data_rd = (state_reg == i2cs_pkg::I2CS_MACK || state_reg == i2cs_pkg::I2CS_ACK)
                 && ack_end && dir_reg && !nack_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      reg_ptr_o <= i2cs_pkg::PTR_RESET;
      wr_data_o <= i2cs_pkg::BYTE_ZERO;
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
    end
    else
    begin
      wr_stb_o <= data_wr;
      rd_stb_o <= data_rd;
      if (ptr_ld)
        reg_ptr_o <= rx_byte;
      else if (wr_stb_o || rd_stb_o)
        reg_ptr_o <= reg_ptr_o + 8'h01;
      if (data_wr)
        wr_data_o <= rx_byte;
    end
  end

  // ************************************************
  // open-drain sda drive, slave only
  // ************************************************
  // only ack or data bits are driven, never at scl high edges: no start/stop
  wire drive_ack = state_reg == i2cs_pkg::I2CS_ACK && state_next == i2cs_pkg::I2CS_ACK &&
                   in_ack_clk;
  // the last read bit stays until scl falls, else a release would look like a stop
  wire hold_last = state_next == i2cs_pkg::I2CS_MACK &&
                   !(state_reg == i2cs_pkg::I2CS_MACK && in_ack_clk);
  wire drive_bit = (state_next == i2cs_pkg::I2CS_SEND || hold_last) && !shift_reg[7];
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sda_oe_o <= 1'b0;
      sda_out_o <= 1'b0;
      busy_o <= 1'b0;
      time_invalid_o <= 1'b0;
    end
    else
    begin
      // released on nack, ignore and idle
      sda_oe_o <= (drive_ack || drive_bit) && !bat_s;
      sda_out_o <= 1'b0;
      busy_o <= (state_next != i2cs_pkg::I2CS_IDLE);
      if (abort_det)
        time_invalid_o <= 1'b1;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_addr_match;
    state_reg == i2cs_pkg::I2CS_RECV && addr_phase_reg && byte_done && addr_hit && !bat_s
      && !start_det && !stop_det;
  endsequence
  // bit eight still high: ack waits with the line released
  sequence s_ack_pending;
    state_reg == i2cs_pkg::I2CS_ACK && !ack_arm_reg && !sda_oe_o;
  endsequence
  // the fall after bit eight opens the ack clock
  sequence s_ack_open;
    state_reg == i2cs_pkg::I2CS_ACK && scl_fall && !ack_arm_reg && !bat_s;
  endsequence
  a_sda_only_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    sda_oe_o |-> !sda_out_o) else $error("sda driven high");
  a_ack_after_addr: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_addr_match |=> s_ack_pending) else $error("address byte not taken");
  a_ack_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_ack_open |=> sda_oe_o) else $error("ack not driven");
  a_sda_steady: assert property (@(posedge core_clk_i) disable iff (srst_i)
    scl_s && scl_d_reg && !bat_s && !start_det && !stop_det |=> $stable(sda_oe_o))
    else $error("sda moved while scl high");
  a_addr_miss_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_reg == i2cs_pkg::I2CS_IGNORE |-> !sda_oe_o) else $error("drove when ignored");
  a_battery_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    bat_s |=> !sda_oe_o && !busy_o) else $error("active on battery");
  a_start_enters: assert property (@(posedge core_clk_i) disable iff (srst_i)
    start_det && !bat_s |=> state_reg == i2cs_pkg::I2CS_RECV) else $error("start missed");
  a_stop_idles: assert property (@(posedge core_clk_i) disable iff (srst_i)
    stop_det |=> state_reg == i2cs_pkg::I2CS_IDLE) else $error("stop missed");
  a_ack_holds: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_reg == i2cs_pkg::I2CS_ACK && ack_arm_reg && scl_s && !bat_s && !stop_det &&
      !start_det |=> sda_oe_o) else $error("ack released early");
  a_nack_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_reg == i2cs_pkg::I2CS_MACK && nack_reg && ack_end |=> !sda_oe_o)
    else $error("held sda after nack");
  a_dir_latch: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_addr_match |=> dir_reg == $past(rx_byte[0])) else $error("direction wrong");
  a_abort_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
    abort_det |=> time_invalid_o) else $error("abort not flagged");
endmodule : i2cs_port

// [test/i2cs_master_bfm.sv]
// Purpose: bus master model facing the i2c slave port
// Assumes: 40 ns core clock, scl period of 8 clocks (320 ns)
// Notes: sda is open drain, the bench resolves the wire
`timescale 1ns/1ps
module i2cs_master_bfm (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // ****
  // bus phases
  // ****
  // both lines released while idle
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // wait n falling core edges
  task automatic tk(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tk
  // sda falls while scl high, only from an idle bus
  task automatic start();
    sda_oe_o = 1'b1;
    tk(4);
    scl_o = 1'b0;
  endtask : start
  // sda rises while scl high
  task automatic stop();
    tk(3);
    sda_oe_o = 1'b1;
    tk(1);
    scl_o = 1'b1;
    tk(4);
    sda_oe_o = 1'b0;
    tk(4);
  endtask : stop
  // one clock; r is unknown if sda moved in the high phase
  task automatic bit_x(input logic b, output logic r);
    logic r1;
    tk(3);
    sda_oe_o = ~b;
    tk(1);
    scl_o = 1'b1;
    tk(1);
    r1 = sda_i;
    tk(3);
    r = (r1 === sda_i) ? r1 : 1'bx;
    scl_o = 1'b0;
  endtask : bit_x
  // eight bits msb first, then the ack clock; mack 1 withholds the ack
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], q[i]);
    end
    bit_x(mack, ack);
  endtask : xfer
endmodule : i2cs_master_bfm

// [test/i2c_slave_port_tb_top.sv]
// Purpose: self-checking bench for the i2c slave port
// Assumes: master model drives scl and pulls sda
// Notes: register file stand-in returns pointer xor 5a
`timescale 1ns/1ps
module i2c_slave_port_tb_top;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic on_battery_i = 1'b0;
  logic scl, m_oe, s_oe, sda_out, wr_stb, rd_stb, busy, t_inv, sda;
  logic [7:0] ptr, wr_data, rd_data;
  int n_errors = 0;
  int tests_run = 0;
  int n_wr = 0;
  int n_rd = 0;
  // ****
  // clock, wire, instances
  // ****
  always #20 core_clk_i = ~core_clk_i;
  // open drain wire with pull-up; read data stand-in
  assign sda = ~(m_oe | s_oe);
  assign rd_data = ptr ^ 8'h5a;
  i2cs_port dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
    .on_battery_i(on_battery_i), .rd_data_i(rd_data), .sda_oe_o(s_oe), .sda_out_o(sda_out),
    .reg_ptr_o(ptr), .wr_data_o(wr_data), .wr_stb_o(wr_stb), .rd_stb_o(rd_stb),
    .busy_o(busy), .time_invalid_o(t_inv));
  i2cs_master_bfm bfm_u (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  // counts write strobes
  always @(posedge core_clk_i)
    n_wr <= n_wr + int'(wr_stb === 1'b1);
  // counts read strobes
  always @(posedge core_clk_i)
    n_rd <= n_rd + int'(rd_stb === 1'b1);
  // ****
  // checking and closing
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // ****
  // scenarios
  // ****
  // pointer byte then two data bytes
  task automatic t_write();
    logic [7:0] q;
    logic a;
    int w0;
    w0 = n_wr;
    bfm_u.start();
    bfm_u.xfer(8'ha2, 1'b1, q, a);
    check(a, 1'b0);
    check(busy, 1'b1);
    bfm_u.xfer(8'h05, 1'b1, q, a);
    check(ptr, 8'h05);
    bfm_u.xfer(8'h3c, 1'b1, q, a);
    bfm_u.xfer(8'h7e, 1'b1, q, a);
    check(a, 1'b0);
    check(wr_data, 8'h7e);
    check(ptr, 8'h07);
    check(8'(n_wr - w0), 8'h02);
    bfm_u.stop();
    check(busy, 1'b0);
  endtask : t_write
  // two bytes from the pointer, last one not acked
  task automatic t_read();
    logic [7:0] q;
    logic a;
    int r0;
    r0 = n_rd;
    bfm_u.start();
    bfm_u.xfer(8'ha3, 1'b1, q, a);
    check(a, 1'b0);
    bfm_u.xfer(8'hff, 1'b0, q, a);
    check(q, 8'h07 ^ 8'h5a);
    check(sda_out, 1'b0);
    bfm_u.xfer(8'hff, 1'b1, q, a);
    check(q, 8'h08 ^ 8'h5a);
    check(8'(n_rd - r0), 8'h02);
    check(ptr, 8'h09);
    bfm_u.tk(6);
    check(sda, 1'b1);
    bfm_u.stop();
  endtask : t_read
  // neighbours of the address get no ack and write nothing
  task automatic t_other_addr();
    logic [7:0] q;
    logic a;
    int w0;
    logic [7:0] bad [2] = '{8'h22, 8'ha1};
    w0 = n_wr;
    foreach (bad[k])
    begin
      bfm_u.start();
      bfm_u.xfer(bad[k], 1'b1, q, a);
      check(a, 1'b1);
      bfm_u.xfer(8'h11, 1'b1, q, a);
      check(a, 1'b1);
      bfm_u.stop();
    end
    check(8'(n_wr - w0), 8'h00);
  endtask : t_other_addr
  // ignored on battery, abort mid frame, resync afterwards
  task automatic t_battery();
    logic [7:0] q;
    logic a;
    on_battery_i = 1'b1;
    bfm_u.start();
    bfm_u.xfer(8'ha2, 1'b1, q, a);
    check(a, 1'b1);
    check(busy, 1'b0);
    bfm_u.stop();
    check(t_inv, 1'b0);
    on_battery_i = 1'b0;
    bfm_u.start();
    bfm_u.xfer(8'ha2, 1'b1, q, a);
    on_battery_i = 1'b1;
    bfm_u.tk(8);
    check(t_inv, 1'b1);
    check(s_oe, 1'b0);
    on_battery_i = 1'b0;
    bfm_u.stop();
    bfm_u.start();
    bfm_u.xfer(8'ha2, 1'b1, q, a);
    check(a, 1'b0);
    bfm_u.stop();
  endtask : t_battery
  // main sequence
  initial
  begin
    repeat (8) @(negedge core_clk_i);
    srst_i = 1'b0;
    bfm_u.tk(4);
    check(busy, 1'b0);
    check(s_oe, 1'b0);
    t_write();
    t_read();
    t_other_addr();
    t_battery();
    wrap_up();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    wrap_up();
  end
endmodule : i2c_slave_port_tb_top
